// File: common/hbp_pkg.sv
// shared constants for the high-band excitation post-filter
package hbp_pkg;
  localparam int FRAME_LEN = 320;
  localparam int SUB_LEN   = 80;
  localparam int SYN_ORD   = 11;
  localparam int PF_ORD    = 10;
  localparam int IMP_LEN   = 20;
  localparam int SEG_STEP  = 10;
  localparam int SEG_LEN   = 20;
  localparam int LAST_LEN  = 15;
  localparam int HEAD_LEN  = 10;
  localparam int NUM_GS    = 4;
  // rate in units of 0.1 kb/s
  localparam logic [15:0] RATE_HI = 16'h00F4;
  // Q12 constants
  localparam logic signed [15:0] ONE_Q12  = 16'sh1000;
  localparam logic signed [15:0] C_065    = 16'sh0A66;
  localparam logic signed [15:0] C_015    = 16'sh0266;
  localparam logic signed [15:0] C_085    = 16'sh0D9A;
  localparam logic signed [15:0] C_075    = 16'sh0C00;
  // segment window, Q15, rising 0.0 .. 1.0
  localparam logic [15:0] WIN_Q15 [0:10] = '{
    16'h0000, 16'h1406, 16'h278E, 16'h3A1C, 16'h4B3D, 16'h5A82,
    16'h678E, 16'h720D, 16'h79BC, 16'h7E6D, 16'h7FFF};
  localparam int WIN_MID = 10;
  typedef enum {ST_IDLE, ST_LOAD, ST_WGT, ST_IMP, ST_ZSYN, ST_SYN,
                ST_POST, ST_AGC, ST_SEG, ST_GSH, ST_DONE} hbp_state_t;
endpackage : hbp_pkg

// File: verilog/hbp_postfilter.sv
// high-band excitation synthesis, post-filter, level equalizer, gains
`timescale 1ns/1ps

module hbp_fifo #(parameter int W = 16, parameter int D = 4) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0]   cnt_reg;
  logic push, pop;
  assign in_ready_o  = (cnt_reg != (AW+1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  always_ff @(posedge core_clk_i) begin
    if (push) mem_reg[wr_reg] <= in_data_i;
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
      if (pop)  rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : hbp_fifo

module hbp_postfilter
  import hbp_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [15:0] rate_i,
  input  wire logic        wideband_operation_i,
  input  wire logic [15:0] voicing_degree_i,
  input  wire logic        coef_we_i,
  input  wire logic [5:0]  coef_addr_i,
  input  wire logic [15:0] coef_data_i,
  input  wire logic        exc_valid_i,
  input  wire logic [15:0] exc_data_i,
  input  wire logic [15:0] tgt_data_i,
  output logic             exc_ready_o,
  output logic [15:0]      out_data_o,
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic [63:0]      temporal_gain_profile_o,
  output logic [15:0]      overlap_scale_o,
  output logic             done_o
);
  typedef logic signed [15:0] s16_t;
  typedef logic signed [47:0] s48_t;

  function automatic s16_t sat16(input s48_t v);
    if (v > 48'sd32767) return 16'sh7FFF;
    if (v < -48'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction : sat16

  // Q12 root of an energy ratio; an empty denominator reads as unity
  function automatic s16_t rsqrt(input s48_t n, input s48_t d);
    logic [79:0] q;
    logic [63:0] x;
    logic [31:0] r;
    q = '0;
    r = '0;
    if (d <= 0) return ONE_Q12;
    q = {32'h0000_0000, n} << 24;
    q = q / {32'h0000_0000, d};
    x = (q[79:64] != '0) ? '1 : q[63:0];
    for (int b = 31; b >= 0; b--) begin
      if (64'(r | (32'h1 << b)) * 64'(r | (32'h1 << b)) <= x)
        r = r | (32'h1 << b);
    end
    return (r > 32'h7FFF) ? 16'sh7FFF : s16_t'(r[15:0]);
  endfunction : rsqrt

  hbp_state_t state_reg;
  logic [8:0] idx_reg;
  logic [2:0] seg_reg;
  logic       high_reg, wb_reg;
  s16_t coef_reg [4][SYN_ORD];
  s16_t exc_mem [FRAME_LEN];
  s16_t tgt_mem [FRAME_LEN];
  s16_t se_mem  [FRAME_LEN];
  s16_t pf_mem  [FRAME_LEN];
  s16_t hat_mem [FRAME_LEN];
  s16_t hist_reg [SYN_ORD], zs_reg [SYN_ORD];
  s16_t nc_reg [PF_ORD], dc_reg [PF_ORD];
  s16_t px_reg [PF_ORD], py_reg [PF_ORD], hh_reg [PF_ORD];
  s16_t ff_reg, bpow_reg, gpow_reg, scale_reg, bsc_reg;
  s48_t tgt_en_reg, zs_en_reg, gf_reg, rh0_reg, rh1_reg;
  s48_t se_en_reg [4], pf_en_reg [4], seg_t_reg [8], seg_e_reg [8];
  s48_t head_reg, body_reg, tail_reg;
  logic [4:0] off_reg;
  logic [1:0] sub;
  logic [1:0] set_sel;
  logic       last, fifo_rdy, push;
  s16_t ein, syn_y, h_n, pf_y, out_s, gsc, bsc_next, ff_next;
  s16_t tw, k1, mu, gt, beta, gamma, win_w, ff_use;
  s48_t acc, u, un, y, t;
  logic [3:0] widx;
  logic [8:0] sidx;

  assign sub  = 2'(idx_reg / 9'(SUB_LEN));
  assign push = (state_reg == ST_AGC) && fifo_rdy;

  always_comb begin
    set_sel = high_reg ? sub : 2'd0;
    // formant factor: smooth, clamp to [0,1], remap
    ff_next = s16_t'((($signed(coef_reg[0][1]) < 0 ?
      -coef_reg[0][1] : coef_reg[0][1]) >>> 1) + (ff_reg >>> 1));
    ff_next = ff_next - ONE_Q12;
    if (ff_next < 0) ff_next = '0;
    if (ff_next > ONE_Q12) ff_next = ONE_Q12;
    ff_next = ONE_Q12 - (ff_next >>> 1);
    // the first weight must already see this frame's factor
    ff_use = (state_reg == ST_WGT && idx_reg == 9'd0) ? ff_next : ff_reg;
    beta  = C_065 - s16_t'((32'(C_015) * 32'(ff_use)) >>> 12);
    gamma = C_065 + s16_t'((32'(C_015) * 32'(ff_use)) >>> 12);
    // synthesis: zero-state history in the first pass
    acc = '0;
    for (int k = 0; k < SYN_ORD; k++)
      acc += 48'(coef_reg[set_sel][k]) *
             48'(state_reg == ST_ZSYN ? zs_reg[k] : hist_reg[k]);
    ein = exc_mem[idx_reg];
    if (state_reg == ST_SYN && high_reg)
      ein = sat16((48'(ein) * 48'(scale_reg)) >>> 12);
    syn_y = sat16(48'(ein) - (acc >>> 12));
    // impulse response of the unnormalized pole-zero filter
    acc = '0;
    for (int k = 0; k < PF_ORD; k++)
      acc += 48'(dc_reg[k]) * 48'(hh_reg[k]);
    u = (idx_reg == 0) ? 48'(ONE_Q12) :
        (idx_reg <= 9'(PF_ORD)) ? -48'(nc_reg[idx_reg[3:0] - 1]) : '0;
    h_n = sat16(u + (acc >>> 12));
    // tilt: k1 = -/r0, weight by sign, gain 1-|mu|
    k1 = (rh0_reg > 0) ? sat16(-((rh1_reg <<< 12) / rh0_reg)) : '0;
    tw = (k1 > 0) ? C_065 : C_085;
    mu = s16_t'((32'(tw) * 32'(k1)) >>> 12);
    gt = ONE_Q12 - ((mu < 0) ? -mu : mu);
    if (gt < 16'sd1) gt = 16'sd1;
    // numerator, normalized by gf, then all-pole denominator
    acc = '0;
    for (int k = 0; k < PF_ORD; k++)
      acc += 48'(nc_reg[k]) * 48'(px_reg[k]);
    u  = 48'(se_mem[idx_reg]) - (acc >>> 12);
    un = (gf_reg > 0) ? (u <<< 12) / gf_reg : u;
    acc = '0;
    for (int k = 0; k < PF_ORD; k++)
      acc += 48'(dc_reg[k]) * 48'(py_reg[k]);
    y  = 48'(sat16(un + (acc >>> 12)));
    t  = y - ((48'(mu) * 48'(py_reg[0])) >>> 12);
    pf_y = sat16((t <<< 12) / 48'(gt));
    // level equalizer
    gsc = rsqrt(se_en_reg[sub], pf_en_reg[sub]);
    bsc_next = s16_t'((32'(C_085) * 32'(bsc_reg) +
                       32'(C_015) * 32'(gsc)) >>> 12);
    out_s = sat16((48'(pf_mem[idx_reg]) * 48'(bsc_next)) >>> 12);
    // segment window index
    if (seg_reg == 3'd0)
      widx = (off_reg < 5) ? 4'(2 * off_reg + 2) :
             (off_reg < 10) ? 4'(WIN_MID) : 4'(19 - off_reg);
    else if (seg_reg == 3'd7)
      widx = (off_reg < 10) ? 4'(off_reg + 1) : 4'(28 - 2 * off_reg);
    else
      widx = (off_reg < 10) ? 4'(off_reg + 1) : 4'(19 - off_reg);
    win_w = s16_t'(WIN_Q15[widx]);
    sidx  = 9'(seg_reg) * 9'(SEG_STEP) + 9'(off_reg);
    last  = (off_reg == 5'((seg_reg == 3'd7) ? LAST_LEN - 1 : SEG_LEN - 1));
  end

  always_ff @(posedge core_clk_i) begin
    if (coef_we_i) coef_reg[coef_addr_i[5:4]][coef_addr_i[3:0]] <= coef_data_i;
    if (exc_valid_i && exc_ready_o) begin
      exc_mem[idx_reg] <= exc_data_i;
      tgt_mem[idx_reg] <= tgt_data_i;
    end
    if (state_reg == ST_SYN)  se_mem[idx_reg]  <= syn_y;
    if (state_reg == ST_POST) pf_mem[idx_reg]  <= pf_y;
    if (push)                 hat_mem[idx_reg] <= out_s;
  end

  // sequencing
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_IDLE;
      idx_reg     <= '0;
      seg_reg     <= '0;
      off_reg     <= '0;
      high_reg    <= 1'b0;
      wb_reg      <= 1'b0;
      exc_ready_o <= 1'b0;
      done_o      <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_reg)
        ST_IDLE: if (start_i) begin
          high_reg    <= (rate_i >= RATE_HI);
          wb_reg      <= wideband_operation_i;
          exc_ready_o <= 1'b1;
          idx_reg     <= '0;
          state_reg   <= ST_LOAD;
        end
        ST_LOAD: if (exc_valid_i) begin
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == 9'(FRAME_LEN - 1)) begin
            exc_ready_o <= 1'b0;
            idx_reg     <= '0;
            state_reg   <= ST_WGT;
          end
        end
        ST_WGT, ST_IMP, ST_ZSYN, ST_SYN, ST_POST, ST_AGC: begin
          if (state_reg != ST_AGC || fifo_rdy) idx_reg <= idx_reg + 1'b1;
          if (state_reg == ST_WGT && idx_reg == 9'(PF_ORD - 1)) begin
            idx_reg   <= '0;
            state_reg <= ST_IMP;
          end
          if (state_reg == ST_IMP && idx_reg == 9'(IMP_LEN - 1)) begin
            idx_reg   <= '0;
            state_reg <= high_reg ? ST_ZSYN : ST_SYN;
          end
          // a stalled last sample must not wrap the frame index
          if (idx_reg == 9'(FRAME_LEN - 1) &&
              (state_reg != ST_AGC || fifo_rdy)) begin
            idx_reg <= '0;
            if (state_reg == ST_ZSYN) state_reg <= ST_SYN;
            if (state_reg == ST_SYN)  state_reg <= ST_POST;
            if (state_reg == ST_POST) state_reg <= ST_AGC;
            if (push) state_reg <= wb_reg ? ST_SEG : ST_GSH;
          end
        end
        ST_SEG: begin
          off_reg <= last ? '0 : off_reg + 1'b1;
          if (last) begin
            seg_reg <= seg_reg + 1'b1;
            if (seg_reg == 3'd7) state_reg <= ST_GSH;
          end
        end
        ST_GSH: begin
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == 9'(NUM_GS - 1)) state_reg <= ST_DONE;
        end
        default: begin
          idx_reg   <= '0;
          done_o    <= 1'b1;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // filter states; kept between frames except zs_reg and hh_reg, which ST_LOAD clears
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < SYN_ORD; k++) begin
        hist_reg[k] <= '0;
        zs_reg[k]   <= '0;
      end
      for (int k = 0; k < PF_ORD; k++) begin
        nc_reg[k] <= '0;
        dc_reg[k] <= '0;
        px_reg[k] <= '0;
        py_reg[k] <= '0;
        hh_reg[k] <= '0;
      end
      ff_reg   <= '0;
      bpow_reg <= '0;
      gpow_reg <= '0;
      bsc_reg  <= ONE_Q12;
    end else begin
      if (state_reg == ST_LOAD) begin
        for (int k = 0; k < SYN_ORD; k++) zs_reg[k] <= '0;
        for (int k = 0; k < PF_ORD; k++) hh_reg[k] <= '0;
      end
      if (state_reg == ST_WGT) begin
        if (idx_reg == 0) ff_reg <= ff_next;
        nc_reg[idx_reg[3:0]] <= s16_t'((32'(coef_reg[0][idx_reg[3:0]]) *
          32'(idx_reg == 0 ? beta : bpow_reg)) >>> 12);
        dc_reg[idx_reg[3:0]] <= s16_t'((32'(coef_reg[0][idx_reg[3:0]]) *
          32'(idx_reg == 0 ? gamma : gpow_reg)) >>> 12);
        bpow_reg <= s16_t'((32'(idx_reg == 0 ? beta : bpow_reg) *
                            32'(beta)) >>> 12);
        gpow_reg <= s16_t'((32'(idx_reg == 0 ? gamma : gpow_reg) *
                            32'(gamma)) >>> 12);
      end
      if (state_reg == ST_IMP)
        hh_reg <= {h_n, hh_reg[0:PF_ORD-2]};
      if (state_reg == ST_ZSYN)
        zs_reg <= {syn_y, zs_reg[0:SYN_ORD-2]};
      if (state_reg == ST_SYN)
        hist_reg <= {syn_y, hist_reg[0:SYN_ORD-2]};
      if (state_reg == ST_POST) begin
        px_reg <= {se_mem[idx_reg], px_reg[0:PF_ORD-2]};
        py_reg <= {s16_t'(y[15:0]), py_reg[0:PF_ORD-2]};
      end
      if (push) bsc_reg <= bsc_next;
    end
  end

  // energies and results
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {tgt_en_reg, zs_en_reg, gf_reg, rh0_reg, rh1_reg} <= '0;
      {head_reg, body_reg, tail_reg} <= '0;
      for (int k = 0; k < 4; k++) begin
        se_en_reg[k] <= '0;
        pf_en_reg[k] <= '0;
      end
      for (int k = 0; k < 8; k++) begin
        seg_t_reg[k] <= '0;
        seg_e_reg[k] <= '0;
      end
      scale_reg               <= ONE_Q12;
      temporal_gain_profile_o <= '0;
      overlap_scale_o         <= 16'h1000;
    end else begin
      case (state_reg)
        ST_IDLE: if (start_i) begin
          {tgt_en_reg, zs_en_reg, gf_reg, rh0_reg, rh1_reg} <= '0;
          {head_reg, body_reg} <= '0;
          for (int k = 0; k < 4; k++) begin
            se_en_reg[k] <= '0;
            pf_en_reg[k] <= '0;
          end
          for (int k = 0; k < 8; k++) begin
            seg_t_reg[k] <= '0;
            seg_e_reg[k] <= '0;
          end
        end
        ST_LOAD: if (exc_valid_i)
          tgt_en_reg <= tgt_en_reg + 48'($signed(tgt_data_i)) *
                                     48'($signed(tgt_data_i));
        ST_IMP: begin
          gf_reg  <= gf_reg + 48'((h_n < 0) ? -h_n : h_n);
          rh0_reg <= rh0_reg + 48'(h_n) * 48'(h_n);
          rh1_reg <= rh1_reg + 48'(h_n) * 48'(hh_reg[0]);
        end
        ST_ZSYN: begin
          zs_en_reg <= zs_en_reg + 48'(syn_y) * 48'(syn_y);
          if (idx_reg == 9'(FRAME_LEN - 1))
            scale_reg <= (zs_en_reg > 0) ? sat16((tgt_en_reg <<< 12) /
              (zs_en_reg + 48'(syn_y) * 48'(syn_y))) : ONE_Q12;
        end
        ST_SYN: begin
          se_en_reg[sub] <= se_en_reg[sub] + 48'(syn_y) * 48'(syn_y);
          // early samples still carry last frame's filter memory
          if (idx_reg < 9'(HEAD_LEN))
            head_reg <= head_reg + 48'(syn_y) * 48'(syn_y);
          else if (idx_reg < 9'(2 * HEAD_LEN))
            body_reg <= body_reg + 48'(syn_y) * 48'(syn_y);
        end
        ST_POST:
          pf_en_reg[sub] <= pf_en_reg[sub] + 48'(pf_y) * 48'(pf_y);
        ST_SEG: begin
          seg_t_reg[seg_reg] <= seg_t_reg[seg_reg] + 48'(sat16(
            (48'(tgt_mem[sidx]) * 48'(win_w)) >>> 15)) ** 2;
          seg_e_reg[seg_reg] <= seg_e_reg[seg_reg] + 48'(sat16(
            (48'(hat_mem[sidx]) * 48'(win_w)) >>> 15)) ** 2;
        end
        ST_GSH: begin
          temporal_gain_profile_o[16*idx_reg[1:0] +: 16] <= wb_reg ?
            rsqrt(seg_t_reg[2*idx_reg[1:0]] + seg_t_reg[2*idx_reg[1:0]+1],
                  seg_e_reg[2*idx_reg[1:0]] + seg_e_reg[2*idx_reg[1:0]+1])
            : temporal_gain_profile_o[16*idx_reg[1:0] +: 16];
          if (idx_reg == 0) begin
            overlap_scale_o <= rsqrt(($signed(voicing_degree_i) > C_075) ?
              (tail_reg + head_reg) >>> 2 : tail_reg + head_reg,
              body_reg);
            tail_reg <= se_en_reg[3] >>> 3;
          end
        end
        default: ;
      endcase
    end
  end

  hbp_fifo #(.W(16), .D(4)) u_out_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (state_reg == ST_AGC),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (out_s),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (out_data_o)
  );

  sequence s_start_idle;
    state_reg == ST_IDLE && start_i;
  endsequence
  sequence s_zs_enter;
    state_reg == ST_IMP && idx_reg == 9'(IMP_LEN - 1) && high_reg;
  endsequence
  a_done_single: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    done_o |=> !done_o) else $error("done longer than one cycle");
  a_frame_ready: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_start_idle |=> exc_ready_o) else $error("no ready after start");
  a_low_rate_set: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == ST_SYN && !high_reg |-> set_sel == 2'd0)
    else $error("low rate used a subframe set");
  a_sub_set: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == ST_SYN && high_reg && idx_reg == 9'd160 |-> set_sel == 2'd2)
    else $error("wrong subframe coefficient set");
  a_zero_state: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_zs_enter |=> state_reg == ST_ZSYN && zs_reg[0] == 0 && zs_reg[10] == 0)
    else $error("first pass memory not cleared");
  a_formant_range: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == ST_WGT && idx_reg == 9'd1 |-> ff_reg >= 16'sh0800 &&
    ff_reg <= ONE_Q12) else $error("formant factor out of range");
  a_tilt_weight: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == ST_POST |-> tw == ((k1 > 0) ? C_065 : C_085))
    else $error("tilt weight wrong");
  a_first_window: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == ST_SEG && seg_reg == 0 && off_reg == 5'd12 |-> widx == 4'd7)
    else $error("first segment window wrong");
  a_agc_stall: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == ST_AGC && !fifo_rdy |=> state_reg == ST_AGC &&
    $stable(idx_reg)) else $error("level equalizer skipped a sample");
endmodule : hbp_postfilter

// File: testbench/hbp_partner.sv
// excitation source and output sink facing the post-filter
`timescale 1ns/1ps
module hbp_partner
  import hbp_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        exc_ready_i,
  input  wire logic [1:0]  tgt_mul_i,
  output logic             exc_valid_o,
  output logic [15:0]      exc_data_o,
  output logic [15:0]      tgt_data_o,
  output logic             out_ready_o
);
  logic signed [15:0] exc_mem [0:319];
  int                 idx = 0;
  logic               take;
  initial begin
    exc_valid_o = 1'b0;
    exc_data_o  = 16'h0000;
    tgt_data_o  = 16'h0000;
    out_ready_o = 1'b0;
  end
  always @(posedge core_clk_i) begin
    take = exc_valid_o && exc_ready_i;
    #1;
    out_ready_o = ($urandom % 2) == 0;
    idx = take ? idx + 1 : idx;
    if (!exc_valid_o || take) begin
      // a beat stays up until taken; idle lines toggle so stale data shows
      if (exc_ready_i && idx < FRAME_LEN && $urandom % 4 != 0) begin
        exc_mem[idx] = ($urandom % 2) ? 16'sh03E8 : -16'sh03E8;
        exc_data_o = exc_mem[idx];
        tgt_data_o = 16'(exc_mem[idx] * $signed({1'b0, tgt_mul_i}));
        exc_valid_o = 1'b1;
      end else begin
        exc_valid_o = 1'b0;
        exc_data_o = ~exc_data_o;
        tgt_data_o = ~tgt_data_o;
      end
    end
    if (!exc_ready_i && !exc_valid_o) idx = 0;
  end
endmodule : hbp_partner

// File: testbench/hbp_postfilter_tb.sv
// self-checking bench for the high-band post-filter
`timescale 1ns/1ps
`define CHK(g, e, t) chk_val((g), (e), (t))
module hbp_postfilter_tb;
  import hbp_pkg::*;
  logic        core_clk_i, rst_n_i, start_i, wideband_operation_i;
  logic        coef_we_i, exc_valid_i, exc_ready_o, out_valid_o;
  logic        out_ready_i, done_o, chk_on;
  logic [5:0]  coef_addr_i;
  logic [1:0]  tgt_mul;
  logic [15:0] rate_i, voicing_degree_i, coef_data_i, exc_data_i;
  logic [15:0] tgt_data_i, out_data_o, overlap_scale_o;
  logic [63:0] temporal_gain_profile_o;
  int          num_errors = 0, n_tests = 0, out_cnt, n, sc;

  hbp_partner part_u (.core_clk_i(core_clk_i), .exc_ready_i(exc_ready_o),
    .tgt_mul_i(tgt_mul), .exc_valid_o(exc_valid_i), .exc_data_o(exc_data_i),
    .tgt_data_o(tgt_data_i), .out_ready_o(out_ready_i));
  hbp_postfilter dut_u (.core_clk_i, .rst_n_i, .start_i, .rate_i,
    .wideband_operation_i, .voicing_degree_i, .coef_we_i, .coef_addr_i,
    .coef_data_i, .exc_valid_i, .exc_data_i, .tgt_data_i, .exc_ready_o,
    .out_data_o, .out_valid_o, .out_ready_i, .temporal_gain_profile_o,
    .overlap_scale_o, .done_o);

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // fixed-point rounding makes exact matches unreliable, hence the tolerance
  task automatic chk_val(input logic signed [31:0] g, e, input int t);
    logic signed [31:0] d;
    d = g - e;
    n_tests++;
    if ((d <= t && d >= -t) !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_val

  function automatic logic [15:0] q12(input real r);
    return 16'($rtoi(r * 4096.0 + 0.5));
  endfunction : q12

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // zero coefficients make every filter stage a pass-through
  always @(posedge core_clk_i) begin
    if (out_valid_o === 1'b1 && out_ready_i && out_cnt < FRAME_LEN) begin
      if (chk_on) `CHK($signed(out_data_o), part_u.exc_mem[out_cnt] * sc, 16);
      out_cnt++;
    end
  end

  initial begin
    void'($urandom(69));
    {rst_n_i, start_i, wideband_operation_i, coef_we_i, chk_on} = '0;
    {rate_i, voicing_degree_i, coef_data_i, coef_addr_i, tgt_mul} = '0;
    out_cnt = 0;
    sc = 1;
    repeat (10) @(posedge core_clk_i);
    #1;
    `CHK(exc_ready_o, 1'b0, 0);
    `CHK(done_o, 1'b0, 0);
    `CHK(out_valid_o, 1'b0, 0);
    `CHK(|temporal_gain_profile_o, 1'b0, 0);
    `CHK(overlap_scale_o, ONE_Q12, 0);
    rst_n_i = 1'b1;
    for (int a = 0; a < 44; a++) begin
      @(posedge core_clk_i);
      #1;
      coef_we_i = 1'b1;
      coef_addr_i = {2'(a / 11), 4'(a % 11)};
    end
    @(posedge core_clk_i);
    #1;
    coef_we_i = 1'b0;
    for (int f = 0; f < 6; f++) begin
      case (f)
        3: rate_i = 16'h00F3;
        4: rate_i = RATE_HI;
        5: rate_i = RATE_HI + 16'($urandom % 64);
        default: rate_i = 16'($urandom % 243);
      endcase
      voicing_degree_i = f == 2 ? 16'h0C00 : f == 3 ? 16'h0C01
                                                     : 16'($urandom % 3072);
      wideband_operation_i = f inside {[1:4]};
      tgt_mul = (f == 3 || f == 4) ? 2'd2 : 2'd1;
      sc = rate_i >= RATE_HI ? tgt_mul * tgt_mul : 1;
      out_cnt = 0;
      chk_on = f > 0;
      start_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      start_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 20000) begin
        @(posedge core_clk_i);
        #1;
        n++;
      end
      if (n == 20000) begin
        num_errors++;
        test_done();
      end
      `CHK(exc_ready_o, 1'b0, 0);
      for (int j = 0; j < NUM_GS && f > 0 && wideband_operation_i; j++)
        `CHK(temporal_gain_profile_o[16*j +: 16], q12(tgt_mul / real'(sc)), 12);
      // only frames whose previous frame had the same level
      if (f inside {[1:3]})
        `CHK(overlap_scale_o, q12($sqrt(voicing_degree_i > 16'h0C00 ? 0.5 : 2.0)), 12);
      @(posedge core_clk_i);
      #1;
      `CHK(done_o, 1'b0, 0);
      n = 0;
      while (out_cnt < FRAME_LEN && n < 100) begin
        @(posedge core_clk_i);
        #1;
        n++;
      end
      `CHK(out_cnt, FRAME_LEN, 0);
      if (out_cnt != FRAME_LEN) test_done();
      $display("frame %0d done", f);
    end
    test_done();
  end
endmodule : hbp_postfilter_tb
